// ==== hdl/pbw_bound.sv ====
/*
 * Aligned-boundary finder: flags the last Dword before an aligned
 * boundary and counts the Dwords left up to it, current one included.
 * Assumes the mask is a power of two minus one.
 */
`timescale 1ns/1ps
module pbw_bound #(
	parameter int AW = 30
) (
	// Address and boundary mask
	input  wire logic [AW-1:0] i_addr,
	input  wire logic [AW-1:0] i_mask,
	// Result
	output logic              o_end,
	output logic [AW-1:0]     o_left
);
	if (AW < 8) begin : g_chk
		$error("pbw_bound: AW too small");
	end

	assign o_end  = (i_addr & i_mask) == i_mask;
	assign o_left = (~i_addr & i_mask) + {{(AW-1){1'b0}}, 1'b1};
endmodule // pbw_bound

// ==== hdl/pbw_pkg.sv ====
/*
 * Package for the bridge write-boundary and read-prefetch policy block:
 * configuration offsets, field positions, reset values, bus command codes,
 * carrier structs and the state record of the policy core.
 * Assumes 32-bit configuration dwords and Dword (30-bit) addresses.
 */
package pbw_pkg;

	// ==========================================================
	// Configuration offsets and fields
	localparam logic [7:0] CFG_CLS_OFF     = 8'h0C;
	localparam logic [7:0] CFG_CHIP_OFF    = 8'h40;
	localparam logic [7:0] CFG_RDCTL_OFF   = 8'h48;
	localparam int         CHIP_WDISC_BIT  = 1;
	localparam int         CHIP_WBUSY_BIT  = 16;
	localparam int         CHIP_RBUSY_BIT  = 17;
	localparam int         RDCTL_UPDIS_BIT = 8;
	localparam logic [7:0] CLS_RST         = 8'h00;
	localparam logic [7:0] MPC_RST         = 8'h00;
	localparam logic       WDISC_RST       = 1'b0;
	localparam logic       UPDIS_RST       = 1'b0;

	// ==========================================================
	// Boundaries and counts, in Dwords
	localparam logic [29:0] DW4K_MASK  = 30'h000003FF;
	localparam logic [29:0] DW16_MASK  = 30'h0000000F;
	localparam logic [7:0]  LINE16     = 8'h10;
	localparam logic [7:0]  CLS_WMAX   = 8'h10;
	localparam logic [7:0]  CLS_RMAX   = 8'h40;
	localparam int          MWI_ROOM   = 8;
	localparam logic [15:0] MIN_PREF   = 16'h0010;
	localparam logic [15:0] ONE_DW     = 16'h0001;

	// ==========================================================
	// Bus command codes
	localparam logic [3:0] CMD_IO_RD  = 4'h2;
	localparam logic [3:0] CMD_IO_WR  = 4'h3;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_CFG_RD = 4'hA;
	localparam logic [3:0] CMD_CFG_WR = 4'hB;
	localparam logic [3:0] CMD_MRM    = 4'hC;
	localparam logic [3:0] CMD_MRL    = 4'hE;
	localparam logic [3:0] CMD_MWI    = 4'hF;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [3:0]  cmd;
		logic [29:0] dw_addr;
		logic        fast_b2b;
	} pbw_wreq_t;

	typedef struct packed {
		logic [3:0]  cmd;
		logic [29:0] dw_addr;
	} pbw_wfwd_t;

	typedef struct packed {
		logic [3:0]  cmd;
		logic [29:0] dw_addr;
		logic [3:0]  be_n;
		logic        upstream;
		logic        in_pref_win;
	} pbw_rreq_t;

	typedef struct packed {
		logic [3:0]  cmd;
		logic [29:0] dw_addr;
		logic        pref;
		logic [3:0]  be_first_n;
		logic [3:0]  be_rest_n;
		logic [15:0] count;
	} pbw_rfwd_t;

	typedef struct packed {
		logic [7:0] cacheline_size_field;
		logic       wdisc;
		logic [7:0] max_prefetch_count_field;
		logic       updis;
	} pbw_cfg_t;

	typedef enum logic [1:0] {
		W_IDLE  = 2'b01,
		W_BURST = 2'b10
	} pbw_wstate_t;

	typedef enum logic [1:0] {
		R_IDLE  = 2'b01,
		R_FETCH = 2'b10
	} pbw_rstate_t;

	typedef struct packed {
		pbw_cfg_t    cfg;
		logic [31:0] cfg_rdata;
		pbw_wstate_t wst;
		logic        wmwi;
		logic [29:0] waddr;
		logic        wstop;
		logic        wacc;
		logic        wretry;
		logic        dtqpush;
		logic        wfvld;
		pbw_wfwd_t   wfwd;
		pbw_rstate_t rst;
		logic        rpref;
		logic [15:0] rcount;
		logic [15:0] rdone;
		logic [29:0] raddr;
		logic        rgo;
		logic        rgstop;
		logic        rfvld;
		pbw_rfwd_t   rfwd;
	} pbw_state_t;

endpackage

// ==== hdl/pbw_policy.sv ====
/*
 * Forwarding policy of a two-bus bridge: write disconnect boundaries,
 * posted/delayed write admission, read classing and prefetch sizing.
 * Assumes the buffer and queue logic around it reports free space on
 * the same clock and moves the data; configuration dwords arrive over
 * the configuration access port below.
 */
`timescale 1ns/1ps
module pbw_policy #(
	parameter int PW_DEPTH   = 32,
	parameter int RB_DEPTH   = 64,
	parameter int PREF_SPARE = 8,
	parameter int PW_W       = $clog2(PW_DEPTH + 1),
	parameter int RB_W       = $clog2(RB_DEPTH + 1)
) (
	// Clock, reset, enable
	input  wire logic              i_clock,
	input  wire logic              i_arst_n,
	input  wire logic              i_clk_en,
	// Configuration access
	input  wire logic              i_cfg_we,
	input  wire logic              i_cfg_re,
	input  wire logic [7:0]        i_cfg_addr,
	input  wire logic [3:0]        i_cfg_be,
	input  wire logic [31:0]       i_cfg_wdata,
	output logic [31:0]            o_cfg_rdata,
	// Write target side
	input  wire logic              i_wr_start,
	input  wire pbw_pkg::pbw_wreq_t i_wr_req,
	input  wire logic              i_wr_dphase,
	input  wire logic              i_wr_last,
	input  wire logic [PW_W-1:0]   i_pw_free,
	input  wire logic [1:0]        i_dtq_free,
	output logic                   o_wr_accept,
	output logic                   o_wr_retry,
	output logic                   o_dtq_push,
	output logic                   o_wr_stop,
	output logic                   o_wr_fwd_vld,
	output pbw_pkg::pbw_wfwd_t     o_wr_fwd,
	// Read request and fetch side
	input  wire logic              i_rd_req,
	input  wire pbw_pkg::pbw_rreq_t i_rd_reqd,
	input  wire logic              i_rd_fetched,
	input  wire logic              i_rd_flow,
	input  wire logic              i_rd_master_end,
	input  wire logic              i_rd_tgt_disc,
	input  wire logic              i_rd_fifo_full,
	input  wire logic [RB_W-1:0]   i_rd_room,
	input  wire logic              i_rd_given,
	output logic                   o_rd_fwd_vld,
	output pbw_pkg::pbw_rfwd_t     o_rd_fwd,
	output logic                   o_rd_fetch_go,
	output logic                   o_rd_give_stop
);
	import pbw_pkg::*;

	if (PW_DEPTH < MWI_ROOM + 1 || RB_DEPTH < 16
	    || PREF_SPARE < 1 || PREF_SPARE > RB_DEPTH) begin : g_chk
		$error("pbw_policy: buffer parameters out of range");
	end

	pbw_state_t st_r;
	pbw_state_t st_nxt;

	// ==========================================================
	// Line size checks
	function automatic logic pow2_upto(logic [7:0] v, logic [7:0] lim);
		return (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00) && (v <= lim);
	endfunction

	logic cls_w_ok;
	logic cls_r_ok;
	logic cls16;
	assign cls_w_ok = pow2_upto(st_r.cfg.cacheline_size_field, CLS_WMAX);
	assign cls_r_ok = pow2_upto(st_r.cfg.cacheline_size_field, CLS_RMAX);
	assign cls16    = st_r.cfg.cacheline_size_field == LINE16;

	// ==========================================================
	// Write boundary look-ahead for the next data phase
	logic           w_busy;
	logic           w_take_dp;
	logic           w_end_now;
	logic           w_slot;
	logic           w_posted;
	logic           w_take;
	logic [29:0]    waddr_n;
	logic           wmwi_n;
	logic [PW_W-1:0] free_now;
	logic           full_n;
	logic           low_n;
	logic [29:0]    wline_mask;
	logic           wline_end;
	logic           w4k_end;
	logic           wstop_n;

	assign w_busy    = st_r.wst == W_BURST;
	assign w_take_dp = w_busy && i_wr_dphase;
	assign w_end_now = w_take_dp && (i_wr_last || st_r.wstop);
	// A fast back-to-back start may land on the closing phase
	assign w_slot    = !w_busy || w_end_now;
	assign w_posted  = i_wr_req.cmd == CMD_MEM_WR
	                || i_wr_req.cmd == CMD_MWI;
	assign w_take    = i_wr_start && w_slot && w_posted
	                && (i_pw_free != '0);
	assign waddr_n   = w_take ? i_wr_req.dw_addr
	                 : w_take_dp ? st_r.waddr + 30'h00000001
	                 : st_r.waddr;
	assign wmwi_n    = w_take ? (i_wr_req.cmd == CMD_MWI && cls_w_ok)
	                 : st_r.wmwi;
	// Free space still counts the phase being taken this cycle
	assign free_now  = i_pw_free - PW_W'(w_take_dp && !w_end_now);
	assign full_n    = free_now <= PW_W'(1);
	assign low_n     = free_now <= PW_W'(MWI_ROOM);
	assign wline_mask = cls_w_ok ? {22'h000000, st_r.cfg.cacheline_size_field - 8'h01}
	                  : DW16_MASK;

	pbw_bound #(.AW(30)) u_wline (
		.i_addr (waddr_n),
		.i_mask (wline_mask),
		.o_end  (wline_end),
		.o_left ()
	);

	pbw_bound #(.AW(30)) u_w4k (
		.i_addr (waddr_n),
		.i_mask (DW4K_MASK),
		.o_end  (w4k_end),
		.o_left ()
	);

	assign wstop_n = w4k_end
	    || full_n
	    || (wline_end && wmwi_n && cls16)
	    || (wline_end && wmwi_n && low_n)
	    || (wline_end && !wmwi_n && st_r.cfg.wdisc && low_n);

	// ==========================================================
	// Read classing and prefetch count
	logic        r_pref;
	logic [29:0] rline_mask;
	logic [29:0] rleft;
	logic [15:0] cacheline_boundary_count;
	logic [15:0] prod;
	logic [15:0] raw_cnt;
	logic [15:0] r_cnt;
	logic        r4k_end;
	logic [15:0] rdone_n;
	logic        r_stop;

	always_comb begin
		unique case (i_rd_reqd.cmd)
			CMD_IO_RD, CMD_CFG_RD: r_pref = 1'b0;
			CMD_MRL, CMD_MRM:      r_pref = 1'b1;
			CMD_MEM_RD:            r_pref = i_rd_reqd.upstream
			                     ? !st_r.cfg.updis
			                     : i_rd_reqd.in_pref_win;
			default:               r_pref = 1'b0;
		endcase
	end

	assign rline_mask = cls_r_ok ? {22'h000000, st_r.cfg.cacheline_size_field - 8'h01}
	                  : DW16_MASK;

	pbw_bound #(.AW(30)) u_rline (
		.i_addr (i_rd_reqd.dw_addr),
		.i_mask (rline_mask),
		.o_end  (),
		.o_left (rleft)
	);

	pbw_bound #(.AW(30)) u_r4k (
		.i_addr (st_r.raddr),
		.i_mask (DW4K_MASK),
		.o_end  (r4k_end),
		.o_left ()
	);

	assign cacheline_boundary_count = rleft[15:0];
	assign prod    = 16'(st_r.cfg.max_prefetch_count_field) * 16'(st_r.cfg.cacheline_size_field);
	assign raw_cnt = (st_r.cfg.max_prefetch_count_field < st_r.cfg.cacheline_size_field) ? cacheline_boundary_count
	               : prod + cacheline_boundary_count;
	assign r_cnt   = !r_pref ? ONE_DW
	               : (raw_cnt < MIN_PREF) ? MIN_PREF : raw_cnt;
	assign rdone_n = st_r.rdone + 16'(i_rd_fetched);

	// Fetch ends on a terminating event, after one Dword if not prefetching, a 4KB boundary, or when the count is used up with no flow and room below PREF_SPARE
	always_comb begin
		r_stop = i_rd_master_end || i_rd_tgt_disc || i_rd_fifo_full;
		if (i_rd_fetched) begin
			if (!st_r.rpref) begin
				r_stop = 1'b1;
			end else if (r4k_end) begin
				r_stop = 1'b1;
			end else if (rdone_n >= st_r.rcount && !i_rd_flow
			             && i_rd_room < RB_W'(PREF_SPARE)) begin
				r_stop = 1'b1;
			end
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		st_nxt         = st_r;
		st_nxt.wacc    = 1'b0;
		st_nxt.wretry  = 1'b0;
		st_nxt.dtqpush = 1'b0;
		st_nxt.wfvld   = 1'b0;
		st_nxt.rfvld   = 1'b0;

		if (i_cfg_we && i_cfg_be[0]) begin
			if (i_cfg_addr == CFG_CLS_OFF) begin
				st_nxt.cfg.cacheline_size_field = i_cfg_wdata[7:0];
			end
			if (i_cfg_addr == CFG_CHIP_OFF) begin
				st_nxt.cfg.wdisc = i_cfg_wdata[CHIP_WDISC_BIT];
			end
			if (i_cfg_addr == CFG_RDCTL_OFF) begin
				st_nxt.cfg.max_prefetch_count_field = i_cfg_wdata[7:0];
			end
		end
		if (i_cfg_we && i_cfg_be[1] && i_cfg_addr == CFG_RDCTL_OFF) begin
			st_nxt.cfg.updis = i_cfg_wdata[RDCTL_UPDIS_BIT];
		end
		if (i_cfg_re) begin
			st_nxt.cfg_rdata = 32'h00000000;
			unique case (i_cfg_addr)
				CFG_CLS_OFF: st_nxt.cfg_rdata[7:0] = st_r.cfg.cacheline_size_field;
				CFG_CHIP_OFF: begin
					st_nxt.cfg_rdata[CHIP_WDISC_BIT] = st_r.cfg.wdisc;
					st_nxt.cfg_rdata[CHIP_WBUSY_BIT] = w_busy;
					st_nxt.cfg_rdata[CHIP_RBUSY_BIT] = st_r.rst == R_FETCH;
				end
				CFG_RDCTL_OFF: begin
					st_nxt.cfg_rdata[7:0] = st_r.cfg.max_prefetch_count_field;
					st_nxt.cfg_rdata[RDCTL_UPDIS_BIT] = st_r.cfg.updis;
				end
				default: st_nxt.cfg_rdata = 32'h00000000;
			endcase
		end

		// Write path
		if (w_end_now) begin
			st_nxt.wst = W_IDLE;
		end
		st_nxt.waddr = waddr_n;
		st_nxt.wmwi  = wmwi_n;
		st_nxt.wstop = wstop_n;
		if (i_wr_start && w_slot) begin
			if (w_take) begin
				st_nxt.wacc  = 1'b1;
				st_nxt.wst   = W_BURST;
				// One forward record per accepted write, no merging
				st_nxt.wfvld = 1'b1;
				st_nxt.wfwd.cmd = wmwi_n ? CMD_MWI : CMD_MEM_WR;
				st_nxt.wfwd.dw_addr = i_wr_req.dw_addr;
			end else if (w_posted) begin
				st_nxt.wretry = 1'b1;
			end else if (i_wr_req.cmd == CMD_IO_WR
			             || i_wr_req.cmd == CMD_CFG_WR) begin
				st_nxt.wretry  = 1'b1;
				st_nxt.dtqpush = i_dtq_free != 2'h0;
			end
		end

		// Read path
		if (i_rd_given) begin
			st_nxt.rgstop = 1'b0;
		end
		unique case (st_r.rst)
			R_IDLE: begin
				if (i_rd_req) begin
					st_nxt.rfvld = 1'b1;
					st_nxt.rfwd.cmd = i_rd_reqd.cmd;
					st_nxt.rfwd.dw_addr = i_rd_reqd.dw_addr;
					st_nxt.rfwd.pref = r_pref;
					st_nxt.rfwd.be_first_n = r_pref ? 4'h0
					                       : i_rd_reqd.be_n;
					st_nxt.rfwd.be_rest_n = 4'h0;
					st_nxt.rfwd.count = r_cnt;
					st_nxt.rpref  = r_pref;
					st_nxt.rcount = r_cnt;
					st_nxt.rdone  = 16'h0000;
					st_nxt.raddr  = i_rd_reqd.dw_addr;
					st_nxt.rgo    = 1'b1;
					st_nxt.rgstop = !r_pref;
					st_nxt.rst    = R_FETCH;
				end
			end
			R_FETCH: begin
				if (i_rd_fetched) begin
					st_nxt.rdone = rdone_n;
					st_nxt.raddr = st_r.raddr + 30'h00000001;
				end
				if (r_stop) begin
					st_nxt.rgo = 1'b0;
					st_nxt.rst = R_IDLE;
				end
			end
		endcase
	end

	// ==========================================================
	// State register
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_r           <= '0;
			st_r.cfg.cacheline_size_field   <= CLS_RST;
			st_r.cfg.max_prefetch_count_field   <= MPC_RST;
			st_r.cfg.wdisc <= WDISC_RST;
			st_r.cfg.updis <= UPDIS_RST;
			st_r.wst       <= W_IDLE;
			st_r.rst       <= R_IDLE;
		end else if (i_clk_en) begin
			st_r <= st_nxt;
		end
	end

	assign o_cfg_rdata    = st_r.cfg_rdata;
	assign o_wr_accept    = st_r.wacc;
	assign o_wr_retry     = st_r.wretry;
	assign o_dtq_push     = st_r.dtqpush;
	assign o_wr_stop      = st_r.wstop;
	assign o_wr_fwd_vld   = st_r.wfvld;
	assign o_wr_fwd       = st_r.wfwd;
	assign o_rd_fwd_vld   = st_r.rfvld;
	assign o_rd_fwd       = st_r.rfwd;
	assign o_rd_fetch_go  = st_r.rgo;
	assign o_rd_give_stop = st_r.rgstop;

	// ==========================================================
	// Checks
	logic a4k_now;
	assign a4k_now = (st_r.waddr & DW4K_MASK) == DW4K_MASK;

	property p_wr_4k;
		@(posedge i_clock) disable iff (!i_arst_n)
		(w_busy && a4k_now) |-> o_wr_stop;
	endproperty
	a_wr_4k: assert property (p_wr_4k)
		else $error("write burst passes a 4KB boundary");

	property p_wr_accept;
		@(posedge i_clock) disable iff (!i_arst_n)
		(i_clk_en && i_wr_start && !w_busy && w_posted && i_pw_free != '0)
		|=> (o_wr_accept && o_wr_fwd_vld && !o_wr_retry);
	endproperty
	a_wr_accept: assert property (p_wr_accept)
		else $error("posted write with room not accepted");

	property p_wr_full_retry;
		@(posedge i_clock) disable iff (!i_arst_n)
		(i_clk_en && i_wr_start && !w_busy && w_posted && i_pw_free == '0)
		|=> (o_wr_retry && !o_wr_accept);
	endproperty
	a_wr_full_retry: assert property (p_wr_full_retry)
		else $error("write without room not retried");

	property p_dtq_push;
		@(posedge i_clock) disable iff (!i_arst_n)
		(i_clk_en && i_wr_start && !w_busy && i_dtq_free != 2'h0
		 && (i_wr_req.cmd == CMD_IO_WR || i_wr_req.cmd == CMD_CFG_WR))
		|=> (o_dtq_push && o_wr_retry);
	endproperty
	a_dtq_push: assert property (p_dtq_push)
		else $error("delayed write not queued");

	property p_rd_iocfg;
		@(posedge i_clock) disable iff (!i_arst_n)
		(o_rd_fwd_vld && (o_rd_fwd.cmd == CMD_IO_RD
		 || o_rd_fwd.cmd == CMD_CFG_RD))
		|-> (!o_rd_fwd.pref && o_rd_fwd.count == ONE_DW);
	endproperty
	a_rd_iocfg: assert property (p_rd_iocfg)
		else $error("I/O or config read prefetched");

	property p_rd_min16;
		@(posedge i_clock) disable iff (!i_arst_n)
		(o_rd_fwd_vld && o_rd_fwd.pref) |-> (o_rd_fwd.count >= MIN_PREF);
	endproperty
	a_rd_min16: assert property (p_rd_min16)
		else $error("prefetch count below sixteen");

	property p_rd_line_mult;
		@(posedge i_clock) disable iff (!i_arst_n)
		(o_rd_fwd_vld && (o_rd_fwd.cmd == CMD_MRL
		 || o_rd_fwd.cmd == CMD_MRM))
		|-> (o_rd_fwd.pref && o_rd_fwd.be_first_n == 4'h0
		     && o_rd_fwd.be_rest_n == 4'h0);
	endproperty
	a_rd_line_mult: assert property (p_rd_line_mult)
		else $error("line or multiple read not prefetchable");

	property p_rd_nonpref;
		@(posedge i_clock) disable iff (!i_arst_n)
		(i_clk_en && i_rd_req && st_r.rst == R_IDLE && !r_pref)
		|=> (o_rd_give_stop && o_rd_fetch_go && o_rd_fwd.count == ONE_DW);
	endproperty
	a_rd_nonpref: assert property (p_rd_nonpref)
		else $error("non-prefetch read not single Dword");

	property p_rd_flow;
		@(posedge i_clock) disable iff (!i_arst_n)
		(i_clk_en && st_r.rst == R_FETCH && st_r.rpref && i_rd_flow
		 && i_rd_fetched && !r4k_end && !i_rd_master_end
		 && !i_rd_tgt_disc && !i_rd_fifo_full) |=> o_rd_fetch_go;
	endproperty
	a_rd_flow: assert property (p_rd_flow)
		else $error("flow-through fetch stopped early");
endmodule // pbw_policy

// ==== tb/pbw_far.sv ====
/*
 * Far-side model: posted write buffer that fills by one Dword per data
 * phase and drains one a cycle on request; read target and read FIFO.
 * Assumes the policy core's clock and reset, PW_DEPTH 32 and RB_DEPTH 64.
 */
`timescale 1ns/1ps
module pbw_far #(
	parameter int PW_DEPTH = 32,
	parameter int RB_DEPTH = 64
) (
	// Clock and reset
	input  wire logic i_clock,
	input  wire logic i_arst_n,
	// Posted write buffer
	input  wire logic i_take,
	input  wire logic i_drain,
	output logic [5:0] o_pw_free,
	// Read target and FIFO
	input  wire logic i_go,
	input  wire logic i_new_rd,
	output logic      o_fetched,
	output logic [6:0] o_room
);
	int held_r;
	int fill_r;

	// ====================
	// Buffer and FIFO levels
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			held_r <= 0;
			fill_r <= 0;
			o_fetched <= 1'b0;
		end else begin
			held_r <= held_r + int'(i_take) - int'(i_drain && held_r > 0);
			// Target answers one Dword a cycle while fill_r, not counting the Dword in flight, is below RB_DEPTH
			o_fetched <= i_go && fill_r < RB_DEPTH;
			fill_r <= i_new_rd ? 0 : fill_r + int'(o_fetched);
		end
	end
	assign o_pw_free = 6'(PW_DEPTH - held_r);
	assign o_room    = 7'(RB_DEPTH - fill_r);
endmodule // pbw_far

// ==== tb/pci_bridge_write_bound_read_prefetch_tb.sv ====
/*
 * Self-checking bench of the bridge policy core: write boundaries,
 * write admission, read classing, prefetch sizing and fetch ending.
 * Assumes the far-side model pbw_far and the default core parameters.
 */
`timescale 1ns/1ps
module pci_bridge_write_bound_read_prefetch_tb;
	import pbw_pkg::*;
	logic        clk, arst_n, cfg_we, cfg_re, wr_start, wr_dphase, drain;
	logic [7:0]  cfg_addr;
	logic [3:0]  cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata;
	pbw_wreq_t   wr_req;
	pbw_wfwd_t   wr_fwd;
	pbw_rreq_t   rd_reqd;
	pbw_rfwd_t   rd_fwd;
	logic [5:0]  pw_free;
	logic [6:0]  rd_room;
	logic [1:0]  dtq_free;
	logic wr_accept, wr_retry, dtq_push, wr_stop, wr_fwd_vld, rd_req;
	logic rd_fetched, rd_flow, rd_mend, rd_given, rd_fwd_vld, rd_go;
	logic give_stop, clk_en, wr_last, tgt_disc;
	int   bad_count, cmp_count, cyc;

	pbw_policy dut (.i_clock(clk), .i_arst_n(arst_n), .i_clk_en(clk_en),
		.i_cfg_we(cfg_we), .i_cfg_re(cfg_re), .i_cfg_addr(cfg_addr),
		.i_cfg_be(cfg_be), .i_cfg_wdata(cfg_wdata), .o_cfg_rdata(cfg_rdata),
		.i_wr_start(wr_start), .i_wr_req(wr_req), .i_wr_dphase(wr_dphase),
		.i_wr_last(wr_last), .i_pw_free(pw_free), .i_dtq_free(dtq_free),
		.o_wr_accept(wr_accept), .o_wr_retry(wr_retry),
		.o_dtq_push(dtq_push), .o_wr_stop(wr_stop),
		.o_wr_fwd_vld(wr_fwd_vld), .o_wr_fwd(wr_fwd), .i_rd_req(rd_req),
		.i_rd_reqd(rd_reqd), .i_rd_fetched(rd_fetched), .i_rd_flow(rd_flow),
		.i_rd_master_end(rd_mend), .i_rd_tgt_disc(tgt_disc),
		.i_rd_fifo_full(rd_room == 7'h00), .i_rd_room(rd_room),
		.i_rd_given(rd_given), .o_rd_fwd_vld(rd_fwd_vld), .o_rd_fwd(rd_fwd),
		.o_rd_fetch_go(rd_go), .o_rd_give_stop(give_stop));

	pbw_far far (.i_clock(clk), .i_arst_n(arst_n), .i_take(wr_dphase),
		.i_drain(drain), .o_pw_free(pw_free), .i_go(rd_go),
		.i_new_rd(rd_fwd_vld), .o_fetched(rd_fetched), .o_room(rd_room));

	// ====================
	// Shared tasks
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// Inputs always move 5 ns after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask

	task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d);
		cfg_addr = a;
		cfg_wdata = d;
		cfg_we = 1'b1;
		tick(1);
		cfg_we = 1'b0;
		// Idle edge so a following strobe never re-rises in this step
		tick(1);
	endtask

	task automatic cfg_chk(input logic [7:0] a, input logic [31:0] e);
		cfg_addr = a;
		cfg_re = 1'b1;
		tick(1);
		cfg_re = 1'b0;
		cmp(64'(cfg_rdata), 64'(e));
		tick(1);
	endtask

	// One burst from an empty buffer, counting phases up to disconnect
	task automatic run_wr(input logic [3:0] c, input logic [7:0] cacheline_size_field,
		input logic wd, input logic [29:0] a, input logic dr,
		input int n_exp, input logic [3:0] c_exp);
		int   n;
		logic s;
		cfg_wr(CFG_CLS_OFF, {24'h000000, cacheline_size_field});
		cfg_wr(CFG_CHIP_OFF, 32'(wd) << CHIP_WDISC_BIT);
		drain = 1'b1;
		tick(40);
		drain = dr;
		wr_req = '{cmd: c, dw_addr: a, fast_b2b: 1'b0};
		wr_start = 1'b1;
		tick(1);
		wr_start = 1'b0;
		cmp(64'({wr_accept, wr_fwd_vld, wr_fwd}), 64'({2'b11, c_exp, a}));
		n = 0;
		wr_dphase = 1'b1;
		do begin
			s = wr_stop;
			n++;
			tick(1);
		end while (s !== 1'b1 && n < 64);
		wr_dphase = 1'b0;
		cmp(64'(n), 64'(n_exp));
	endtask

	task automatic wr_try(input logic [3:0] c, input logic b,
		input logic [2:0] e);
		wr_req = '{cmd: c, dw_addr: 30'h00000100, fast_b2b: b};
		wr_start = 1'b1;
		tick(1);
		wr_start = 1'b0;
		cmp(64'({wr_accept, wr_retry, dtq_push}), 64'(e));
		tick(1);
	endtask

	task automatic run_rd(input logic [3:0] c, input logic up,
		input logic w, input logic p, input logic [15:0] cnt);
		pbw_rfwd_t e;
		rd_reqd = '{cmd: c, dw_addr: 30'h1, be_n: 4'hA, upstream: up,
			in_pref_win: w};
		rd_req = 1'b1;
		tick(1);
		rd_req = 1'b0;
		e = '{cmd: c, dw_addr: 30'h1, pref: p, be_first_n: p ? 4'h0 : 4'hA,
			be_rest_n: 4'h0, count: cnt};
		cmp(64'({rd_fwd_vld, rd_go, rd_fwd}), 64'({2'b11, e}));
		if (p) begin
			tick(40);
			cmp(64'(rd_go), 64'h1);
			rd_mend = 1'b1;
			tick(1);
			rd_mend = 1'b0;
			tick(1);
			cmp(64'(rd_go), 64'h0);
		end else begin
			tick(4);
			cmp(64'({rd_go, give_stop}), 64'h1);
			rd_given = 1'b1;
			tick(1);
			rd_given = 1'b0;
			cmp(64'(give_stop), 64'h0);
		end
		tick(2);
	endtask

	// Flow-through: fetching runs past count to an end; only with disc does it also run past the room limit
	task automatic flow_rd(input logic [29:0] a, input logic disc);
		rd_reqd = '{cmd: CMD_MRL, dw_addr: a, be_n: 4'hF, upstream: 1'b0,
			in_pref_win: 1'b0};
		rd_flow = 1'b1;
		rd_req = 1'b1;
		tick(1);
		rd_req = 1'b0;
		cmp(64'({rd_fwd_vld, rd_go, rd_fwd.count}), 64'h30010);
		// Without flow the room limit would end the fetch near cycle 60
		tick(disc ? 60 : 40);
		cmp(64'(rd_go), 64'h1);
		tgt_disc = disc;
		tick(disc ? 1 : 11);
		tgt_disc = 1'b0;
		tick(1);
		cmp(64'(rd_go), 64'h0);
		rd_flow = 1'b0;
		tick(2);
	endtask

	// ====================
	// Scenarios
	task automatic t_cfg();
		cfg_chk(CFG_CLS_OFF, 32'h00000000);
		cfg_chk(CFG_CHIP_OFF, 32'h00000000);
		cfg_chk(CFG_RDCTL_OFF, 32'h00000000);
		// A write while the enable is low must not land
		clk_en = 1'b0;
		cfg_wr(CFG_CLS_OFF, 32'h00000008);
		clk_en = 1'b1;
		cfg_chk(CFG_CLS_OFF, 32'h00000000);
		cfg_wr(8'h10, 32'hFFFFFFFF);
		cfg_chk(8'h10, 32'h00000000);
		cfg_be = 4'h1;
		cfg_wr(CFG_RDCTL_OFF, 32'h00000108);
		cfg_chk(CFG_RDCTL_OFF, 32'h00000008);
		cfg_be = 4'hF;
		$display("test config done");
	endtask

	task automatic t_write();
		run_wr(CMD_MEM_WR, 8'h00, 1'b0, 30'h3FD, 1'b1, 3, CMD_MEM_WR);
		run_wr(CMD_MEM_WR, 8'h04, 1'b1, 30'h0, 1'b0, 28, CMD_MEM_WR);
		run_wr(CMD_MWI, 8'h04, 1'b0, 30'h0, 1'b0, 28, CMD_MWI);
		run_wr(CMD_MWI, 8'h10, 1'b0, 30'h13, 1'b1, 13, CMD_MWI);
		run_wr(CMD_MWI, 8'h08, 1'b0, 30'h3F9, 1'b1, 7, CMD_MWI);
		run_wr(CMD_MWI, 8'h03, 1'b0, 30'h3FE, 1'b1, 2, CMD_MEM_WR);
		run_wr(CMD_MEM_WR, 8'h00, 1'b0, 30'h0, 1'b0, 32, CMD_MEM_WR);
		wr_try(CMD_MEM_WR, 1'b1, 3'b010);
		wr_try(CMD_MEM_WR, 1'b0, 3'b010);
		dtq_free = 2'h1;
		wr_try(CMD_IO_WR, 1'b0, 3'b011);
		dtq_free = 2'h0;
		wr_try(CMD_CFG_WR, 1'b0, 3'b010);
		drain = 1'b1;
		tick(40);
		wr_try(CMD_MEM_WR, 1'b0, 3'b100);
		// Fast back-to-back start on the closing phase of the open burst
		wr_dphase = 1'b1;
		wr_last = 1'b1;
		wr_try(CMD_MEM_WR, 1'b1, 3'b100);
		wr_dphase = 1'b0;
		wr_last = 1'b0;
		cfg_chk(CFG_CHIP_OFF, 32'h00000000);
		$display("test writes done");
	endtask

	task automatic t_read();
		cfg_wr(CFG_CLS_OFF, 32'h00000004);
		cfg_wr(CFG_RDCTL_OFF, 32'h00000008);
		run_rd(CMD_IO_RD, 1'b0, 1'b1, 1'b0, 16'h1);
		run_rd(CMD_CFG_RD, 1'b0, 1'b1, 1'b0, 16'h1);
		run_rd(CMD_MEM_RD, 1'b0, 1'b1, 1'b1, 16'd35);
		run_rd(CMD_MEM_RD, 1'b0, 1'b0, 1'b0, 16'h1);
		run_rd(CMD_MEM_RD, 1'b1, 1'b0, 1'b1, 16'd35);
		run_rd(CMD_MRM, 1'b0, 1'b0, 1'b1, 16'd35);
		run_rd(CMD_MRL, 1'b0, 1'b0, 1'b1, 16'd35);
		cfg_wr(CFG_RDCTL_OFF, 32'h00000108);
		run_rd(CMD_MEM_RD, 1'b1, 1'b0, 1'b0, 16'h1);
		cfg_wr(CFG_CLS_OFF, 32'h00000040);
		cfg_wr(CFG_RDCTL_OFF, 32'h00000002);
		run_rd(CMD_MRL, 1'b0, 1'b0, 1'b1, 16'd63);
		cfg_wr(CFG_CLS_OFF, 32'h00000001);
		cfg_wr(CFG_RDCTL_OFF, 32'h00000001);
		run_rd(CMD_MRL, 1'b0, 1'b0, 1'b1, 16'd16);
		flow_rd(30'h00000001, 1'b1);
		flow_rd(30'h000003D0, 1'b0);
		$display("test reads done");
	endtask

	// ====================
	// Clock, watchdog and main sequence
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Whole run needs about 940 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			bad_count++;
			report_and_stop();
		end
	end

	initial begin
		{arst_n, cfg_we, cfg_re, wr_start, wr_dphase, drain} = '0;
		{rd_req, rd_flow, rd_mend, rd_given, dtq_free} = '0;
		{wr_last, tgt_disc} = '0;
		clk_en = 1'b1;
		{cfg_addr, cfg_wdata, wr_req, rd_reqd} = '0;
		cfg_be = 4'hF;
		tick(4);
		arst_n = 1'b1;
		tick(1);
		t_cfg();
		t_write();
		t_read();
		report_and_stop();
	end
endmodule // pci_bridge_write_bound_read_prefetch_tb
